// >>> legacy_kbd_pkg.sv
// Constants shared by the keyboard trap and gate sequence logic.
package legacy_kbd_pkg;
    // Configuration offsets (byte addresses).
    localparam logic [7:0] OFF_USB_IO_BASE = 8'h20;
    localparam logic [7:0] OFF_LEGACY_CTRL = 8'hC0;
    localparam logic [7:0] OFF_MISC_SUPPORT = 8'hFF;

    // Legacy control field positions.
    localparam int BIT_PASSTHRU_END_ST = 15;
    localparam int BIT_USB_IRQ_ST = 12;
    localparam int BIT_TRAP_ST_LO = 8;
    localparam int BIT_SMI_ON_END_EN = 7;
    localparam int BIT_IN_PROGRESS = 6;
    localparam int BIT_PASSTHRU_EN = 5;
    localparam int BIT_USB_IRQ_SMI_EN = 4;
    localparam int BIT_CMD_WR_TRAP_EN = 3;
    localparam int BIT_CMD_RD_TRAP_EN = 2;
    localparam int BIT_DATA_WR_TRAP_EN = 1;
    localparam int BIT_DATA_RD_TRAP_EN = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL_WRITE_MASK = 8'hBF;

    // Base address register layout.
    localparam int BASE_LO = 5;
    localparam int BASE_HI = 15;
    localparam logic [10:0] BASE_RESET = 11'h000;
    localparam logic IO_SPACE_INDICATOR = 1'b1;

    // Misc support register layout.
    localparam int BIT_RTC_INDEX_RD_EN = 4;
    localparam logic MISC_RESET = 1'b0;

    // Legacy ports and sequence data codes.
    localparam logic [15:0] PORT_DATA = 16'h0060;
    localparam logic [15:0] PORT_CMD = 16'h0064;
    localparam logic [15:0] PORT_RTC_INDEX = 16'h0070;
    localparam logic [7:0] CODE_GATE_CMD = 8'hD1;
    localparam logic [7:0] CODE_SEQ_END = 8'hFF;
    localparam int GATE_DATA_BIT = 1;

    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b001,
        SEQ_GOT_CMD = 3'b010,
        SEQ_ACTIVE = 3'b100
    } seq_state_t;
endpackage : legacy_kbd_pkg

// >>> kbd_seq_if.sv
// Carrier between the trap logic and the gate sequence recogniser.
interface kbd_seq_if;
    logic enable;
    logic acc_valid;
    logic acc_write;
    logic acc_cmd;
    logic acc_data;
    logic [7:0] acc_byte;
    logic absorb;
    logic seq_end;
    logic gate_load;
    logic in_progress;

    modport hub (
        output enable, acc_valid, acc_write, acc_cmd, acc_data, acc_byte,
        input absorb, seq_end, gate_load, in_progress
    );
    modport seq (
        input enable, acc_valid, acc_write, acc_cmd, acc_data, acc_byte,
        output absorb, seq_end, gate_load, in_progress
    );
endinterface : kbd_seq_if

// >>> gate_seq_fsm.sv
// Recogniser for the address line gate pass-through command sequence.
module gate_seq_fsm (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    kbd_seq_if.seq bus
);
    legacy_kbd_pkg::seq_state_t state_q;
    legacy_kbd_pkg::seq_state_t state_d;
    logic cmd_wr;
    logic start_wr;
    logic end_wr;

    assign cmd_wr = bus.acc_valid & bus.acc_write & bus.acc_cmd;
    assign start_wr = cmd_wr & (bus.acc_byte == legacy_kbd_pkg::CODE_GATE_CMD);
    assign end_wr = cmd_wr & (bus.acc_byte == legacy_kbd_pkg::CODE_SEQ_END);

    always_comb begin
        state_d = state_q;
        bus.absorb = 1'b0;
        bus.seq_end = 1'b0;
        bus.gate_load = 1'b0;
        case (state_q)
            legacy_kbd_pkg::SEQ_IDLE: begin
                if (bus.enable && start_wr) begin
                    state_d = legacy_kbd_pkg::SEQ_GOT_CMD;
                    bus.absorb = 1'b1;
                end
            end
            legacy_kbd_pkg::SEQ_GOT_CMD: begin
                if (start_wr) begin
                    bus.absorb = 1'b1;
                end else if (bus.acc_valid && bus.acc_write && bus.acc_data) begin
                    state_d = legacy_kbd_pkg::SEQ_ACTIVE;
                    bus.absorb = 1'b1;
                    bus.gate_load = 1'b1;
                end else if (bus.acc_valid && (bus.acc_cmd || bus.acc_data)) begin
                    state_d = legacy_kbd_pkg::SEQ_IDLE;
                    bus.seq_end = 1'b1;
                end
            end
            legacy_kbd_pkg::SEQ_ACTIVE: begin
                // tolerate command port, end on FFh
                if (end_wr) begin
                    state_d = legacy_kbd_pkg::SEQ_IDLE;
                    bus.absorb = 1'b1;
                    bus.seq_end = 1'b1;
                end else if (bus.acc_valid && bus.acc_cmd) begin
                    bus.absorb = 1'b1;
                end else if (bus.acc_valid && bus.acc_data) begin
                    state_d = legacy_kbd_pkg::SEQ_IDLE;
                    bus.seq_end = 1'b1;
                end
            end
            default: begin
                state_d = legacy_kbd_pkg::SEQ_IDLE;
            end
        endcase
        // disable ends sequence immediately
        // Without this absorb, seq_end and gate_load could still fire in the cycle after the enable write.
        if (!bus.enable) begin
            state_d = legacy_kbd_pkg::SEQ_IDLE;
            bus.absorb = 1'b0;
            bus.seq_end = 1'b0;
            bus.gate_load = 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst || !bus.enable) begin
            state_q <= legacy_kbd_pkg::SEQ_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    assign bus.in_progress = (state_q != legacy_kbd_pkg::SEQ_IDLE) & bus.enable;
endmodule : gate_seq_fsm

// >>> legacy_kbd_trap.sv
// Legacy keyboard port trap, gate pass-through and USB configuration registers.
module legacy_kbd_trap (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    // Configuration cycles.
    input wire logic i_cfg_valid,
    input wire logic i_cfg_write,
    input wire logic [7:0] i_cfg_addr,
    input wire logic [3:0] i_cfg_be,
    input wire logic [31:0] i_cfg_wdata,
    output logic o_cfg_ack,
    output logic [31:0] o_cfg_rdata,
    // I/O cycles.
    input wire logic i_io_valid,
    input wire logic i_io_write,
    input wire logic [15:0] i_io_addr,
    input wire logic [7:0] i_io_wdata,
    output logic o_io_claim,
    output logic [7:0] o_io_rdata,
    output logic o_usb_io_hit,
    output logic o_io_trap,
    // Side signals.
    input wire logic i_usb_irq,
    input wire logic [6:0] i_rtc_index,
    output logic o_addr_line_gate,
    output logic o_passthru_in_progress,
    output logic o_system_mgmt_interrupt_n
);
    kbd_seq_if seq_bus ();

    logic [15:5] base_q;
    logic [7:0] ctrl_q;
    logic [3:0] trap_st_q;
    logic end_st_q;
    logic rtc_en_q;
    logic gate_q;

    logic cfg_wr;
    logic base_sel;
    logic ctrl_sel;
    logic misc_sel;
    logic io_rd;
    logic io_wr;
    logic at_data;
    logic at_cmd;
    logic [3:0] trap_hit;
    logic [3:0] trap_clr;
    logic end_clr;
    logic smi_req;
    logic [31:0] rdata_d;

    function automatic logic port_is(
        input logic [15:0] addr,
        input logic [15:0] port
    );
        port_is = (addr == port);
    endfunction : port_is

    function automatic logic dword_is(
        input logic [7:0] addr,
        input logic [7:0] off
    );
        dword_is = (addr[7:2] == off[7:2]);
    endfunction : dword_is

    // Register selection, dword aligned.
    assign cfg_wr = i_cfg_valid & i_cfg_write;
    assign base_sel = dword_is(i_cfg_addr, legacy_kbd_pkg::OFF_USB_IO_BASE);
    assign ctrl_sel = dword_is(i_cfg_addr, legacy_kbd_pkg::OFF_LEGACY_CTRL);
    assign misc_sel = dword_is(i_cfg_addr, legacy_kbd_pkg::OFF_MISC_SUPPORT);

    // Legacy port access classification.
    assign io_rd = i_io_valid & ~i_io_write;
    assign io_wr = i_io_valid & i_io_write;
    assign at_data = port_is(i_io_addr, legacy_kbd_pkg::PORT_DATA);
    assign at_cmd = port_is(i_io_addr, legacy_kbd_pkg::PORT_CMD);

    assign seq_bus.enable = ctrl_q[legacy_kbd_pkg::BIT_PASSTHRU_EN];
    assign seq_bus.acc_valid = i_io_valid;
    assign seq_bus.acc_write = i_io_write;
    assign seq_bus.acc_cmd = at_cmd;
    assign seq_bus.acc_data = at_data;
    assign seq_bus.acc_byte = i_io_wdata;

    gate_seq_fsm u_seq (
        .i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst),
        .bus(seq_bus)
    );

    // Trap detection; bit order matches the status field.
    always_comb begin
        trap_hit = 4'h0;
        trap_hit[3] = io_wr & at_cmd & ctrl_q[legacy_kbd_pkg::BIT_CMD_WR_TRAP_EN];
        trap_hit[2] = io_rd & at_cmd & ctrl_q[legacy_kbd_pkg::BIT_CMD_RD_TRAP_EN];
        trap_hit[1] = io_wr & at_data & ctrl_q[legacy_kbd_pkg::BIT_DATA_WR_TRAP_EN];
        trap_hit[0] = io_rd & at_data & ctrl_q[legacy_kbd_pkg::BIT_DATA_RD_TRAP_EN];
        if (seq_bus.absorb) begin
            trap_hit = 4'h0;
        end
    end

    // Write-one-clear strobes from the upper control byte.
    always_comb begin
        trap_clr = 4'h0;
        end_clr = 1'b0;
        if (cfg_wr && ctrl_sel && i_cfg_be[1]) begin
            trap_clr = i_cfg_wdata[11:8];
            end_clr = i_cfg_wdata[legacy_kbd_pkg::BIT_PASSTHRU_END_ST];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            base_q <= legacy_kbd_pkg::BASE_RESET;
        end else if (cfg_wr && base_sel) begin
            if (i_cfg_be[0]) begin
                base_q[7:5] <= i_cfg_wdata[7:5];
            end
            if (i_cfg_be[1]) begin
                base_q[15:8] <= i_cfg_wdata[15:8];
            end
        end
    end

    // Enables; the running bit is never stored.
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            ctrl_q <= legacy_kbd_pkg::CTRL_RESET;
        end else if (cfg_wr && ctrl_sel && i_cfg_be[0]) begin
            ctrl_q <= i_cfg_wdata[7:0] & legacy_kbd_pkg::CTRL_WRITE_MASK;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            trap_st_q <= 4'h0;
        end else begin
            trap_st_q <= (trap_st_q & ~trap_clr) | trap_hit;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            end_st_q <= 1'b0;
        end else begin
            end_st_q <= (end_st_q & ~end_clr) | seq_bus.seq_end;
        end
    end

    // Only the top byte lane reaches the misc register.
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            rtc_en_q <= legacy_kbd_pkg::MISC_RESET;
        end else if (cfg_wr && misc_sel && i_cfg_be[3]) begin
            rtc_en_q <= i_cfg_wdata[24 + legacy_kbd_pkg::BIT_RTC_INDEX_RD_EN];
        end
    end

    // The data byte of a recognised sequence drives the gate line.
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            gate_q <= 1'b0;
        end else if (seq_bus.gate_load) begin
            gate_q <= i_io_wdata[legacy_kbd_pkg::GATE_DATA_BIT];
        end
    end

    // Read data assembly.
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (base_sel) begin
            rdata_d[legacy_kbd_pkg::BASE_HI:legacy_kbd_pkg::BASE_LO] = base_q;
            rdata_d[0] = legacy_kbd_pkg::IO_SPACE_INDICATOR;
        end else if (ctrl_sel) begin
            rdata_d[7:0] = ctrl_q;
            rdata_d[legacy_kbd_pkg::BIT_IN_PROGRESS] = seq_bus.in_progress;
            rdata_d[11:8] = trap_st_q;
            rdata_d[legacy_kbd_pkg::BIT_USB_IRQ_ST] = i_usb_irq;
            rdata_d[legacy_kbd_pkg::BIT_PASSTHRU_END_ST] = end_st_q;
        end else if (misc_sel) begin
            rdata_d[24 + legacy_kbd_pkg::BIT_RTC_INDEX_RD_EN] = rtc_en_q;
        end
    end

    // Configuration answers one cycle after the request.
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_cfg_ack <= 1'b0;
            o_cfg_rdata <= 32'h0000_0000;
        end else begin
            o_cfg_ack <= i_cfg_valid;
            if (i_cfg_valid && !i_cfg_write) begin
                o_cfg_rdata <= rdata_d;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_io_claim <= 1'b0;
            o_io_rdata <= 8'h00;
        end else begin
            o_io_claim <= io_rd & rtc_en_q & port_is(i_io_addr, legacy_kbd_pkg::PORT_RTC_INDEX);
            o_io_rdata <= {1'b0, i_rtc_index};
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_usb_io_hit <= 1'b0;
        end else begin
            o_usb_io_hit <= i_io_valid & (i_io_addr[15:5] == base_q);
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_io_trap <= 1'b0;
        end else begin
            o_io_trap <= |trap_hit;
        end
    end

    always_comb begin
        smi_req = |(trap_st_q & ctrl_q[3:0]);
        smi_req = smi_req | (end_st_q & ctrl_q[legacy_kbd_pkg::BIT_SMI_ON_END_EN]);
        smi_req = smi_req | (i_usb_irq & ctrl_q[legacy_kbd_pkg::BIT_USB_IRQ_SMI_EN]);
    end

    // Trap status bits are set only when their trap enable is on, so the mask above
    // keeps a later disable from holding the request forever.
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_system_mgmt_interrupt_n <= 1'b1;
            o_addr_line_gate <= 1'b0;
            o_passthru_in_progress <= 1'b0;
        end else begin
            o_system_mgmt_interrupt_n <= ~smi_req;
            o_addr_line_gate <= gate_q;
            o_passthru_in_progress <= seq_bus.in_progress;
        end
    end
endmodule : legacy_kbd_trap

// >>> kbd_trap_chk.sv
// Port-level assertions for the legacy keyboard trap block.
module kbd_trap_chk (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_cfg_valid,
    input wire logic i_cfg_write,
    input wire logic o_cfg_ack,
    input wire logic [31:0] o_cfg_rdata,
    input wire logic i_io_valid,
    input wire logic i_io_write,
    input wire logic [15:0] i_io_addr,
    input wire logic o_io_claim,
    input wire logic [7:0] o_io_rdata,
    input wire logic o_usb_io_hit,
    input wire logic o_io_trap,
    input wire logic [6:0] i_rtc_index,
    input wire logic o_system_mgmt_interrupt_n
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_sys_rst);

    a_ack_follows_req: assert property (i_cfg_valid |=> o_cfg_ack)
        else $error("config ack missing");
    a_ack_has_cause: assert property (o_cfg_ack |-> $past(i_cfg_valid))
        else $error("config ack without request");
    a_rdata_holds: assert property (
        !$past(i_cfg_valid && !i_cfg_write) |-> $stable(o_cfg_rdata))
        else $error("read data moved without a read");
    a_trap_port_only: assert property (o_io_trap |-> $past(i_io_valid &&
        (i_io_addr == 16'h0060 || i_io_addr == 16'h0064)))
        else $error("trap on a foreign port");
    a_trap_raises_smi: assert property (o_io_trap |=> !o_system_mgmt_interrupt_n)
        else $error("trap without management interrupt");
    a_claim_index_rd: assert property (o_io_claim |->
        $past(i_io_valid && !i_io_write && i_io_addr == 16'h0070))
        else $error("claim without index read");
    a_claim_index_val: assert property (
        o_io_claim |-> o_io_rdata == {1'b0, $past(i_rtc_index)})
        else $error("index readback value wrong");
    a_hit_has_cause: assert property (o_usb_io_hit |-> $past(i_io_valid))
        else $error("base hit without access");

    c_claim: cover property (o_io_claim);
    c_trap: cover property (o_io_trap);
    c_smi: cover property ($fell(o_system_mgmt_interrupt_n));
endmodule : kbd_trap_chk

// >>> host_bfm.sv
// Host model issuing configuration and I/O cycles at the falling edge.
module host_bfm (
    input wire logic i_clk,
    input wire logic i_ack,
    input wire logic [31:0] i_rdata,
    output logic o_cv,
    output logic o_cw,
    output logic [7:0] o_ca,
    output logic [3:0] o_cbe,
    output logic [31:0] o_cwd,
    output logic o_iv,
    output logic o_iw,
    output logic [15:0] o_ia,
    output logic [7:0] o_iwd
);
    initial begin
        {o_cv, o_cw, o_ca, o_cbe, o_cwd} = '0;
        {o_iv, o_iw, o_ia, o_iwd} = '0;
    end

    task automatic cfg(input logic w, input logic [7:0] a, input logic [3:0] be,
        input logic [31:0] d, output logic [31:0] r, output logic ok);
        @(negedge i_clk);
        o_cv = 1'b1;
        o_cw = w;
        o_ca = a;
        o_cbe = be;
        o_cwd = d;
        @(negedge i_clk);
        o_cv = 1'b0;
        // Released address and data lines show a changed value so stale data never matches.
        o_ca = ~a;
        o_cwd = ~d;
        ok = i_ack;
        r = i_rdata;
    endtask : cfg

    task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(negedge i_clk);
        o_iv = 1'b1;
        o_iw = w;
        o_ia = a;
        o_iwd = d;
        @(negedge i_clk);
        o_iv = 1'b0;
        o_ia = ~a;
        o_iwd = ~d;
    endtask : io
endmodule : host_bfm

// >>> test_legacy_kbd_trap.sv
// Testbench for the legacy keyboard trap block.
module test_legacy_kbd_trap;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cv, cw, ack, iv, iw, claim, hit, trap, gate, busy, smi_n;
    logic [7:0] ca, iwd, iord;
    logic [3:0] cbe;
    logic [31:0] cwd, crd;
    logic [15:0] ia;
    logic irq = 1'b0;
    logic [6:0] idx = 7'h5A;
    int err_count = 0;
    int checks_done = 0;

    always #10 clk = ~clk;

    host_bfm u_host (.i_clk(clk), .i_ack(ack), .i_rdata(crd), .o_cv(cv), .o_cw(cw),
        .o_ca(ca), .o_cbe(cbe), .o_cwd(cwd), .o_iv(iv), .o_iw(iw), .o_ia(ia), .o_iwd(iwd));

    legacy_kbd_trap u_dut (.i_sys_clk(clk), .i_sys_rst(rst), .i_cfg_valid(cv),
        .i_cfg_write(cw), .i_cfg_addr(ca), .i_cfg_be(cbe), .i_cfg_wdata(cwd),
        .o_cfg_ack(ack), .o_cfg_rdata(crd), .i_io_valid(iv), .i_io_write(iw),
        .i_io_addr(ia), .i_io_wdata(iwd), .o_io_claim(claim), .o_io_rdata(iord),
        .o_usb_io_hit(hit), .o_io_trap(trap), .i_usb_irq(irq), .i_rtc_index(idx),
        .o_addr_line_gate(gate), .o_passthru_in_progress(busy),
        .o_system_mgmt_interrupt_n(smi_n));

    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks_done++;
        if (got !== exp) begin
            $display("CHECK FAILED %0t %s got %h", $time, m, got);
            err_count++;
        end
    endtask : chk

    task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] be,
        input logic [31:0] d, input logic [31:0] e, input string m);
        logic [31:0] r;
        logic ok;
        u_host.cfg(w, a, be, d, r, ok);
        chk(32'(ok), 32'h1, "no ack");
        if (ok !== 1'b1) begin
            end_sim();
        end else if (!w) begin
            chk(r, e, m);
        end
    endtask : acc

    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        acc(1'b1, a, be, d, 32'h0, "");
    endtask : wr

    task automatic pio(input logic w, input logic [15:0] a, input logic [7:0] d,
        input logic t, input string m);
        u_host.io(w, a, d);
        chk(32'(trap), 32'(t), m);
    endtask : pio

    initial begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        acc(1'b0, 8'h20, 4'hF, 0, 32'h0000_0001, "base reset");
        acc(1'b0, 8'hC0, 4'h3, 0, 32'h0000_0000, "ctrl reset");
        acc(1'b0, 8'hFC, 4'h8, 0, 32'h0000_0000, "misc reset");
        wr(8'h20, 4'hF, 32'h0000_FFFF);
        acc(1'b0, 8'h20, 4'hF, 0, 32'h0000_FFE1, "base value");
        pio(1'b0, 16'hFFF3, 8'h00, 1'b0, "hit trap");
        chk(32'(hit), 32'h1, "base hit");
        pio(1'b0, 16'hFFD3, 8'h00, 1'b0, "miss trap");
        chk(32'(hit), 32'h0, "base miss");
        wr(8'hFC, 4'h8, 32'h1F00_0000);
        acc(1'b0, 8'hFC, 4'h8, 0, 32'h1000_0000, "misc bits");
        pio(1'b0, 16'h0070, 8'h00, 1'b0, "index trap");
        chk(32'(claim), 32'h1, "index claim");
        chk(32'(iord[6:0]), 32'h5A, "index value");
        wr(8'hFC, 4'h8, 32'h0000_0000);
        pio(1'b0, 16'h0070, 8'h00, 1'b0, "index trap off");
        chk(32'(claim), 32'h0, "readback off");
        for (int i = 0; i < 4; i++) begin
            pio(i[0], (i < 2) ? 16'h0060 : 16'h0064, 8'h00, 1'b0, "trap off");
            wr(8'hC0, 4'h1, 32'h1 << i);
            pio(i[0], (i < 2) ? 16'h0060 : 16'h0064, 8'h00, 1'b1, "trap on");
            @(negedge clk);
            chk(32'(smi_n), 32'h0, "trap smi");
            acc(1'b0, 8'hC0, 4'h3, 0, (32'h101 << i), "trap status");
            wr(8'hC0, 4'h2, 32'h100 << i);
            @(negedge clk);
            chk(32'(smi_n), 32'h1, "smi released");
            wr(8'hC0, 4'h1, 32'h0);
        end
        irq = 1'b1;
        repeat (3) @(negedge clk);
        chk(32'(smi_n), 32'h1, "irq masked");
        wr(8'hC0, 4'h1, 32'h0000_0010);
        repeat (2) @(negedge clk);
        chk(32'(smi_n), 32'h0, "irq smi");
        acc(1'b0, 8'hC0, 4'h3, 0, 32'h0000_1010, "irq status");
        irq = 1'b0;
        wr(8'hC0, 4'h1, 32'h0000_00AF);
        repeat (2) @(negedge clk);
        chk(32'(smi_n), 32'h1, "irq gone");
        pio(1'b1, 16'h0064, 8'hD1, 1'b0, "first cmd");
        pio(1'b1, 16'h0064, 8'hD1, 1'b0, "repeat cmd");
        pio(1'b1, 16'h0060, 8'h02, 1'b0, "gate data");
        acc(1'b0, 8'hC0, 4'h3, 0, 32'h0000_00EF, "running");
        chk(32'(busy), 32'h1, "busy port");
        pio(1'b0, 16'h0064, 8'h00, 1'b0, "status poll");
        pio(1'b1, 16'h0064, 8'hFF, 1'b0, "end code");
        chk(32'(gate), 32'h1, "gate set");
        acc(1'b0, 8'hC0, 4'h3, 0, 32'h0000_80AF, "seq end");
        chk(32'(busy), 32'h0, "busy clear");
        chk(32'(smi_n), 32'h0, "end smi");
        wr(8'hC0, 4'h2, 32'h0000_8000);
        @(negedge clk);
        chk(32'(smi_n), 32'h1, "end smi cleared");
        pio(1'b1, 16'h0064, 8'hD1, 1'b0, "cmd again");
        pio(1'b0, 16'h0060, 8'h00, 1'b1, "deviation");
        acc(1'b0, 8'hC0, 4'h3, 0, 32'h0000_81AF, "deviation status");
        wr(8'hC0, 4'h2, 32'h0000_8100);
        pio(1'b1, 16'h0064, 8'hD1, 1'b0, "cmd third");
        pio(1'b1, 16'h0060, 8'h00, 1'b0, "gate data low");
        @(negedge clk);
        chk(32'(busy), 32'h1, "busy again");
        wr(8'hC0, 4'h1, 32'h0000_0000);
        @(negedge clk);
        chk(32'(busy), 32'h0, "abort idle");
        chk(32'(gate), 32'h0, "gate low");
        acc(1'b0, 8'hC0, 4'h3, 0, 32'h0000_0000, "abort status");
        end_sim();
    end

    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        end_sim();
    end
endmodule : test_legacy_kbd_trap

bind legacy_kbd_trap kbd_trap_chk u_chk (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
    .i_cfg_valid(i_cfg_valid), .i_cfg_write(i_cfg_write), .o_cfg_ack(o_cfg_ack),
    .o_cfg_rdata(o_cfg_rdata), .i_io_valid(i_io_valid), .i_io_write(i_io_write),
    .i_io_addr(i_io_addr), .o_io_claim(o_io_claim), .o_io_rdata(o_io_rdata),
    .o_usb_io_hit(o_usb_io_hit), .o_io_trap(o_io_trap), .i_rtc_index(i_rtc_index),
    .o_system_mgmt_interrupt_n(o_system_mgmt_interrupt_n));
